/* hdl/spgc_pkg.sv */
// Shared constants for the sleep and power gating control block
package spgc_pkg;
   // ---------------------------------------------
   // Register offsets (data space)
   // ---------------------------------------------
   localparam logic [7:0] SPGC_OFS_SLEEP = 8'h53;
   localparam logic [7:0] SPGC_OFS_SYSCTL = 8'h55;
   localparam logic [7:0] SPGC_OFS_GATE2 = 8'h63;
   localparam logic [7:0] SPGC_OFS_GATE0 = 8'h64;
   localparam logic [7:0] SPGC_OFS_GATE1 = 8'h65;
   localparam logic [7:0] SPGC_IO_DELTA = 8'h20;
   localparam logic [7:0] SPGC_IO_LIMIT = 8'h40;
   // ---------------------------------------------
   // Field positions and masks
   // ---------------------------------------------
   localparam int SPGC_B_SLEEP_EN = 0;
   localparam int SPGC_B_SEL_LO = 1;
   localparam int SPGC_B_DBG_OFF = 7;
   localparam int SPGC_B_BOD_OFF = 6;
   localparam int SPGC_B_BOD_UNL = 5;
   localparam int SPGC_B_PULL_OFF = 4;
   localparam int SPGC_B_VEC_SEL = 1;
   localparam int SPGC_B_VEC_UNL = 0;
   localparam int SPGC_B_TIMER2 = 6;
   localparam logic [7:0] SPGC_MASK_SLEEP = 8'h0f;
   localparam logic [7:0] SPGC_MASK_SYSCTL = 8'hf3;
   localparam logic [7:0] SPGC_MASK_GATE0 = 8'hff;
   localparam logic [7:0] SPGC_MASK_GATE1 = 8'h03;
   localparam logic [7:0] SPGC_MASK_GATE2 = 8'h0f;
   localparam logic [7:0] SPGC_RESET_VAL = 8'h00;
   // ---------------------------------------------
   // Sleep mode codes
   // ---------------------------------------------
   localparam logic [2:0] SPGC_SM_IDLE = 3'h0;
   localparam logic [2:0] SPGC_SM_NOISE = 3'h1;
   localparam logic [2:0] SPGC_SM_PDOWN = 3'h2;
   localparam logic [2:0] SPGC_SM_PSAVE = 3'h3;
   localparam logic [2:0] SPGC_SM_STBY = 3'h6;
   localparam logic [2:0] SPGC_SM_XSTBY = 3'h7;
   // ---------------------------------------------
   // Timed sequence windows, in cycles
   // ---------------------------------------------
   localparam logic [2:0] SPGC_UNLOCK_CYC = 3'h4;
   localparam logic [2:0] SPGC_BOD_DELAY_CYC = 3'h3;
   localparam logic [2:0] SPGC_BOD_HOLD_CYC = 3'h3;
   // ---------------------------------------------
   // Controller command registers (own map)
   // ---------------------------------------------
   localparam logic [3:0] SPGC_CMD_ADDR = 4'h0;
   localparam logic [3:0] SPGC_CMD_WDATA = 4'h1;
   localparam logic [3:0] SPGC_CMD_GO = 4'h2;
   localparam logic [3:0] SPGC_CMD_RDATA = 4'h3;
   localparam logic [3:0] SPGC_CMD_STATUS = 4'h4;
   localparam int SPGC_GO_WRITE = 0;
   localparam int SPGC_GO_READ = 1;
   localparam int SPGC_GO_SLEEP = 2;
endpackage

/* hdl/spgc_if.sv */
// Core-to-block access carrier for the sleep and power gating control
`timescale 1ns/10ps
`default_nettype none
interface spgc_if;
   logic [7:0] addr;
   logic io_space;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic sleep_instr;
   logic sleep_taken;
   logic bod_off_req;
   logic irq_block;
   logic [2:0] sleep_mode;
   modport device (
      input addr, io_space, wdata, wr, rd, sleep_instr,
      output rdata, sleep_taken, bod_off_req, irq_block, sleep_mode
   );
   modport core (
      output addr, io_space, wdata, wr, rd, sleep_instr,
      input rdata, sleep_taken, bod_off_req, irq_block, sleep_mode
   );
endinterface
`default_nettype wire

/* hdl/spgc_device.sv */
// Sleep mode, system control and clock gating registers
// Operation
// - Three-bit field selects one of six sleep modes
// - Sleep instruction sleeps only with enable set
// - Software sets enable before, clears after sleep
// - Registers answer at data offsets; sleep and system control also at I/O
// - Debug disable bit turns debug port off
// - Debug bit changes on two equal writes
// - Brown-out off needs unlock then set write
// - Brown-out bit active after three, clears three later
// - Sleep while bit active requests detector off
// - Pull-up disable forces all pull-ups off
// - Vector select picks program or boot base
// - Vector select changes only after unlock write
// - Interrupts blocked during vector change sequence
// - Vector unlock clears after four or select write
// - Boot lock blocks interrupts in locked section
// - Group zero gates eight peripheral clocks
// - Group one gates timers four and three
// - Group two gates touch, serial, two-wire
// - Timer two gated only in synchronous mode
// - Gated timers resume from held state
// - Software reinitialises serial units after ungating
// - Converter disabled by software before gating
// - Gated peripheral frozen until bit cleared
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module spgc_device
   import spgc_pkg::*;
#(
   parameter int BOOT_ADDR_W = 16
)(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Core side
   spgc_if.device bus,
   // Fuses and straps
   input wire logic debug_port_fuse_in,
   input wire logic [BOOT_ADDR_W-1:0] boot_size_fuse_in,
   input wire logic app_boot_lock_in,
   input wire logic boot_boot_lock_in,
   input wire logic exec_in_boot_in,
   input wire logic timer2_async_select_in,
   // Controls to the chip
   output logic debug_port_enable_out,
   output logic pullup_disable_out,
   output logic [BOOT_ADDR_W-1:0] vector_base_out,
   output logic [7:0] clock_stop_grp0_out,
   output logic [1:0] clock_stop_grp1_out,
   output logic [3:0] clock_stop_grp2_out
);
   // ---------------------------------------------
   // Address decode
   // ---------------------------------------------
   function automatic logic [7:0] spgc_norm(input logic [7:0] a,
                                            input logic io);
      spgc_norm = (io && a < SPGC_IO_LIMIT) ? a + SPGC_IO_DELTA : a;
   endfunction

   logic [7:0] ofs;
   logic wr_sleep, wr_sys, wr_g0, wr_g1, wr_g2;
   assign ofs = spgc_norm(bus.addr, bus.io_space);
   assign wr_sleep = bus.wr && ofs == SPGC_OFS_SLEEP;
   assign wr_sys = bus.wr && ofs == SPGC_OFS_SYSCTL;
   assign wr_g0 = bus.wr && ofs == SPGC_OFS_GATE0;
   assign wr_g1 = bus.wr && ofs == SPGC_OFS_GATE1;
   assign wr_g2 = bus.wr && ofs == SPGC_OFS_GATE2;

   logic [3:0] sleep_reg;
   logic [7:0] g0_reg;
   logic [1:0] g1_reg;
   logic [3:0] g2_reg;
   logic dbg_off_reg, pull_off_reg, vec_sel_reg, vec_unl_reg;
   logic bod_off_reg, bod_unl_reg;

   // ---------------------------------------------
   // Sleep control and gating registers
   // ---------------------------------------------
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         sleep_reg <= 4'h0;
         g0_reg <= SPGC_RESET_VAL;
         g1_reg <= 2'h0;
         g2_reg <= 4'h0;
         pull_off_reg <= 1'b0;
      end
      else
      begin
         if (wr_sleep)
            sleep_reg <= bus.wdata[3:0] & SPGC_MASK_SLEEP[3:0];
         if (wr_g0)
            g0_reg <= bus.wdata & SPGC_MASK_GATE0;
         if (wr_g1)
            g1_reg <= bus.wdata[1:0];
         if (wr_g2)
            g2_reg <= bus.wdata[3:0];
         if (wr_sys)
            pull_off_reg <= bus.wdata[SPGC_B_PULL_OFF];
      end
   end

   // ---------------------------------------------
   // Debug disable: two equal writes in four cycles
   // ---------------------------------------------
   logic [2:0] dbg_cnt_reg;
   logic dbg_val_reg;
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         dbg_off_reg <= 1'b0;
         dbg_cnt_reg <= 3'h0;
         dbg_val_reg <= 1'b0;
      end
      else if (wr_sys)
      begin
         if (dbg_cnt_reg != 3'h0 &&
             dbg_val_reg == bus.wdata[SPGC_B_DBG_OFF])
         begin
            dbg_off_reg <= bus.wdata[SPGC_B_DBG_OFF];
            dbg_cnt_reg <= 3'h0;
         end
         else
         begin
            dbg_val_reg <= bus.wdata[SPGC_B_DBG_OFF];
            dbg_cnt_reg <= SPGC_UNLOCK_CYC;
         end
      end
      else if (dbg_cnt_reg != 3'h0)
         dbg_cnt_reg <= dbg_cnt_reg - 3'h1;
   end

   // ---------------------------------------------
   // Brown-out sleep-off timed sequence
   // ---------------------------------------------
   logic [2:0] bod_unl_cnt_reg, bod_age_reg;
   logic bod_active;
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         bod_unl_reg <= 1'b0;
         bod_unl_cnt_reg <= 3'h0;
         bod_off_reg <= 1'b0;
         bod_age_reg <= 3'h0;
      end
      else
      begin
         if (wr_sys && bus.wdata[SPGC_B_BOD_OFF] &&
             bus.wdata[SPGC_B_BOD_UNL])
         begin
            bod_unl_reg <= 1'b1;
            bod_unl_cnt_reg <= SPGC_UNLOCK_CYC;
         end
         else if (wr_sys && bod_unl_reg)
         begin
            bod_unl_reg <= 1'b0;
            bod_unl_cnt_reg <= 3'h0;
            if (bus.wdata[SPGC_B_BOD_OFF] && !bus.wdata[SPGC_B_BOD_UNL])
            begin
               bod_off_reg <= 1'b1;
               bod_age_reg <= 3'h0;
            end
         end
         else if (bod_unl_cnt_reg != 3'h0)
         begin
            bod_unl_cnt_reg <= bod_unl_cnt_reg - 3'h1;
            if (bod_unl_cnt_reg == 3'h1)
               bod_unl_reg <= 1'b0;
         end
         if (bod_off_reg && !(wr_sys && bod_unl_reg))
         begin
            if (bod_age_reg == SPGC_BOD_DELAY_CYC + SPGC_BOD_HOLD_CYC - 3'h1)
               bod_off_reg <= 1'b0;
            bod_age_reg <= bod_age_reg + 3'h1;
         end
      end
   end
   assign bod_active = bod_off_reg && bod_age_reg >= SPGC_BOD_DELAY_CYC;

   // ---------------------------------------------
   // Interrupt vector select with unlock
   // ---------------------------------------------
   logic [2:0] vec_cnt_reg;
   logic post_sel_reg;
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         vec_sel_reg <= 1'b0;
         vec_unl_reg <= 1'b0;
         vec_cnt_reg <= 3'h0;
         post_sel_reg <= 1'b0;
      end
      else
      begin
         post_sel_reg <= 1'b0;
         if (wr_sys && vec_unl_reg && !bus.wdata[SPGC_B_VEC_UNL])
         begin
            vec_sel_reg <= bus.wdata[SPGC_B_VEC_SEL];
            vec_unl_reg <= 1'b0;
            vec_cnt_reg <= 3'h0;
            post_sel_reg <= 1'b1;
         end
         else if (wr_sys && bus.wdata[SPGC_B_VEC_UNL])
         begin
            vec_unl_reg <= 1'b1;
            vec_cnt_reg <= SPGC_UNLOCK_CYC;
         end
         else if (vec_cnt_reg != 3'h0)
         begin
            vec_cnt_reg <= vec_cnt_reg - 3'h1;
            if (vec_cnt_reg == 3'h1)
               vec_unl_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Sleep entry
   // ---------------------------------------------
   logic taken_reg, bod_req_reg;
   logic [2:0] mode_reg;
   logic sel_ok;
   assign sel_ok = sleep_reg[3:1] != 3'h4 && sleep_reg[3:1] != 3'h5;
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         taken_reg <= 1'b0;
         bod_req_reg <= 1'b0;
         mode_reg <= SPGC_SM_IDLE;
      end
      else
      begin
         taken_reg <= bus.sleep_instr && sleep_reg[SPGC_B_SLEEP_EN]
                      && sel_ok;
         bod_req_reg <= bus.sleep_instr && sleep_reg[SPGC_B_SLEEP_EN]
                        && sel_ok && bod_active;
         if (bus.sleep_instr && sleep_reg[SPGC_B_SLEEP_EN])
            mode_reg <= sleep_reg[3:1];
      end
   end

   // ---------------------------------------------
   // Read-back
   // ---------------------------------------------
   logic [7:0] rdata_reg;
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         rdata_reg <= 8'h00;
      else if (bus.rd)
         case (ofs)
            SPGC_OFS_SLEEP: rdata_reg <= {4'h0, sleep_reg};
            SPGC_OFS_SYSCTL: rdata_reg <= {dbg_off_reg, bod_off_reg,
                                  bod_unl_reg, pull_off_reg, 2'h0,
                                  vec_sel_reg, vec_unl_reg};
            SPGC_OFS_GATE0: rdata_reg <= g0_reg;
            SPGC_OFS_GATE1: rdata_reg <= {6'h00, g1_reg};
            SPGC_OFS_GATE2: rdata_reg <= {4'h0, g2_reg};
            default: rdata_reg <= 8'h00;
         endcase
      else
         rdata_reg <= 8'h00;
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   logic lock_block;
   assign lock_block = (vec_sel_reg && app_boot_lock_in && !exec_in_boot_in)
      || (!vec_sel_reg && boot_boot_lock_in && exec_in_boot_in);
   assign bus.rdata = rdata_reg;
   assign bus.sleep_taken = taken_reg;
   assign bus.bod_off_req = bod_req_reg;
   assign bus.sleep_mode = mode_reg;
   assign bus.irq_block = vec_unl_reg || post_sel_reg || lock_block;
   assign debug_port_enable_out = debug_port_fuse_in && !dbg_off_reg;
   assign pullup_disable_out = pull_off_reg;
   assign vector_base_out = vec_sel_reg ? boot_size_fuse_in
                                        : '0;
   // Held gates freeze state, clearing resumes it
   assign clock_stop_grp0_out = {g0_reg[7],
      g0_reg[SPGC_B_TIMER2] && !timer2_async_select_in,
      g0_reg[5:0]};
   assign clock_stop_grp1_out = g1_reg;
   assign clock_stop_grp2_out = g2_reg;
endmodule
`default_nettype wire

/* hdl/spgc_core.sv */
// Core-side access controller driving the block through command registers
`timescale 1ns/10ps
`default_nettype none
module spgc_core
   import spgc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Software port
   input wire logic [3:0] sw_addr_in,
   input wire logic [7:0] sw_wdata_in,
   input wire logic sw_wr_in,
   input wire logic sw_rd_in,
   output logic [7:0] sw_rdata_out,
   // Block side
   spgc_if.core bus
);
   typedef enum logic [1:0] {
      SPGC_ST_IDLE = 2'b01,
      SPGC_ST_WAIT = 2'b10
   } spgc_state_t;

   spgc_state_t state_reg;
   logic [7:0] addr_reg, wdata_reg, rdata_reg, sw_rdata_reg;
   logic io_reg, wr_reg, rd_reg, slp_reg, cap_reg;
   logic taken_reg, bodreq_reg;

   // ---------------------------------------------
   // Command registers and strobes
   // ---------------------------------------------
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         addr_reg <= 8'h00;
         io_reg <= 1'b0;
         wdata_reg <= 8'h00;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         slp_reg <= 1'b0;
      end
      else
      begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         slp_reg <= 1'b0;
         if (sw_wr_in && sw_addr_in == SPGC_CMD_ADDR)
            addr_reg <= sw_wdata_in;
         if (sw_wr_in && sw_addr_in == SPGC_CMD_WDATA)
            wdata_reg <= sw_wdata_in;
         if (sw_wr_in && sw_addr_in == SPGC_CMD_GO)
         begin
            io_reg <= sw_wdata_in[7];
            wr_reg <= sw_wdata_in[SPGC_GO_WRITE];
            rd_reg <= sw_wdata_in[SPGC_GO_READ] && !sw_wdata_in[SPGC_GO_WRITE];
            slp_reg <= sw_wdata_in[SPGC_GO_SLEEP];
         end
      end
   end

   // ---------------------------------------------
   // Read capture and status
   // ---------------------------------------------
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         state_reg <= SPGC_ST_IDLE;
         rdata_reg <= 8'h00;
         cap_reg <= 1'b0;
         taken_reg <= 1'b0;
         bodreq_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            SPGC_ST_IDLE:
               if (rd_reg)
                  state_reg <= SPGC_ST_WAIT;
            SPGC_ST_WAIT:
            begin
               rdata_reg <= bus.rdata;
               state_reg <= SPGC_ST_IDLE;
            end
            default: state_reg <= SPGC_ST_IDLE;
         endcase
         cap_reg <= state_reg == SPGC_ST_WAIT;
         // Sticky sleep results, set wins over clear
         if (bus.sleep_taken)
            taken_reg <= 1'b1;
         else if (sw_rd_in && sw_addr_in == SPGC_CMD_STATUS)
            taken_reg <= 1'b0;
         if (bus.bod_off_req)
            bodreq_reg <= 1'b1;
         else if (sw_rd_in && sw_addr_in == SPGC_CMD_STATUS)
            bodreq_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         sw_rdata_reg <= 8'h00;
      else if (sw_rd_in)
         case (sw_addr_in)
            SPGC_CMD_ADDR: sw_rdata_reg <= addr_reg;
            SPGC_CMD_WDATA: sw_rdata_reg <= wdata_reg;
            SPGC_CMD_RDATA: sw_rdata_reg <= rdata_reg;
            SPGC_CMD_STATUS: sw_rdata_reg <= {bus.sleep_mode, bus.irq_block,
                                  cap_reg, state_reg == SPGC_ST_WAIT,
                                  bodreq_reg, taken_reg};
            default: sw_rdata_reg <= 8'h00;
         endcase
      else
         sw_rdata_reg <= 8'h00;
   end

   assign sw_rdata_out = sw_rdata_reg;
   assign bus.addr = addr_reg;
   assign bus.io_space = io_reg;
   assign bus.wdata = wdata_reg;
   assign bus.wr = wr_reg;
   assign bus.rd = rd_reg;
   assign bus.sleep_instr = slp_reg;
endmodule
`default_nettype wire

/* bench/spgc_monitor.sv */
// Concurrent checks on the carrier between core controller and block
`timescale 1ns/10ps
`default_nettype none
module spgc_monitor
   import spgc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Carrier signals
   input wire logic [7:0] addr,
   input wire logic io_space,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic sleep_instr,
   input wire logic sleep_taken,
   input wire logic bod_off_req,
   input wire logic irq_block,
   input wire logic [2:0] sleep_mode
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [7:0] ofs;
   logic sys_wr;
   logic legal;
   logic mapped;
   logic bod_act;
   logic [3:0] sm_reg;
   logic [2:0] unl_reg;
   logic [2:0] bod_reg;
   // -------------------------------------------
   // Shadow of the timed sequences
   // -------------------------------------------
   assign ofs = (io_space && addr < SPGC_IO_LIMIT) ?
                addr + SPGC_IO_DELTA : addr;
   assign sys_wr = wr && ofs == SPGC_OFS_SYSCTL;
   assign legal = sm_reg[3:2] != 2'b10;
   assign mapped = ofs inside {SPGC_OFS_SLEEP, SPGC_OFS_SYSCTL,
                   SPGC_OFS_GATE0, SPGC_OFS_GATE1, SPGC_OFS_GATE2};
   // Last three of six set cycles count as active
   assign bod_act = bod_reg != 3'h0 && bod_reg < 3'h4;
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         sm_reg <= 4'h0;
      else if (wr && ofs == SPGC_OFS_SLEEP)
         sm_reg <= wdata[3:0];
   end
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         unl_reg <= 3'h0;
      else if (sys_wr)
         unl_reg <= (wdata[6:5] == 2'b11) ? 3'h4 : 3'h0;
      else if (unl_reg != 3'h0)
         unl_reg <= unl_reg - 3'h1;
   end
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         bod_reg <= 3'h0;
      else if (sys_wr && wdata[6:5] == 2'b10 && unl_reg != 3'h0)
         bod_reg <= 3'h6;
      else if (bod_reg != 3'h0)
         bod_reg <= bod_reg - 3'h1;
   end
   // -------------------------------------------
   // Properties
   // -------------------------------------------
   sequence s_vec_unlock;
      sys_wr && wdata[SPGC_B_VEC_UNL];
   endsequence
   sequence s_sleep_ok;
      sleep_instr && sm_reg[0] && legal;
   endsequence
   a_no_dual_strobe: assert property (!(wr && rd))
      else $error("write and read strobes together");
   a_wr_single_pulse: assert property (wr |=> !wr)
      else $error("write strobe longer than one cycle");
   a_rdata_idle_zero: assert property (rdata != 8'h00 |-> $past(rd))
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (rd && !mapped |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_sleep_readback: assert property
      (rd && ofs == SPGC_OFS_SLEEP |=> rdata == {4'h0, $past(sm_reg)})
      else $error("sleep register read back wrong");
   a_sleep_taken_due: assert property (s_sleep_ok |=> sleep_taken)
      else $error("enabled sleep not taken");
   a_taken_cause: assert property
      (sleep_taken |-> $past(sleep_instr) && $past(sm_reg[0]) && $past(legal))
      else $error("sleep taken without enable or legal mode");
   a_mode_shown: assert property
      (sleep_taken |-> sleep_mode == $past(sm_reg[3:1]))
      else $error("sleep mode differs from selected field");
   a_bod_request: assert property (s_sleep_ok ##0 bod_act |=> bod_off_req)
      else $error("detector off request missing");
   a_bod_cause: assert property
      (bod_off_req |-> sleep_taken && $past(bod_act))
      else $error("detector off request without active bit");
   a_vec_block: assert property (s_vec_unlock |=> irq_block [*3])
      else $error("interrupts not blocked after vector unlock");
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the core controller and block pair
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin n_checks++; if ((got) !== (ex)) begin errors++; \
   $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_top
   import spgc_pkg::*;
;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [7:0] sw_rdata;
   logic dbg_fuse = 1'b1;
   logic [15:0] boot_fuse = 16'h0000;
   logic app_lock = 1'b0;
   logic boot_lock = 1'b0;
   logic in_boot = 1'b0;
   logic t2_async = 1'b0;
   logic dbg_en;
   logic pull_off;
   logic [15:0] vec_base;
   logic [7:0] stop0;
   logic [1:0] stop1;
   logic [3:0] stop2;
   logic [7:0] rnd = 8'h03;
   logic [7:0] gv [3];
   logic [7:0] gofs [3] = '{8'h64, 8'h65, 8'h63};
   logic [7:0] gmsk [3] = '{8'hff, 8'h03, 8'h0f};
   logic [7:0] rofs [7] = '{8'h53, 8'h55, 8'h63, 8'h64, 8'h65, 8'h54, 8'h66};
   int errors = 0;
   int n_checks = 0;
   always #4 core_clk_in = ~core_clk_in;
   spgc_if i_spgc_if ();
   spgc_core i_spgc_core (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr),
      .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata), .bus(i_spgc_if));
   spgc_device i_spgc_device (.core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in), .bus(i_spgc_if),
      .debug_port_fuse_in(dbg_fuse), .boot_size_fuse_in(boot_fuse),
      .app_boot_lock_in(app_lock), .boot_boot_lock_in(boot_lock),
      .exec_in_boot_in(in_boot), .timer2_async_select_in(t2_async),
      .debug_port_enable_out(dbg_en), .pullup_disable_out(pull_off),
      .vector_base_out(vec_base), .clock_stop_grp0_out(stop0),
      .clock_stop_grp1_out(stop1), .clock_stop_grp2_out(stop2));
   spgc_monitor i_spgc_monitor (.core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in), .addr(i_spgc_if.addr),
      .io_space(i_spgc_if.io_space), .wdata(i_spgc_if.wdata),
      .wr(i_spgc_if.wr), .rd(i_spgc_if.rd), .rdata(i_spgc_if.rdata),
      .sleep_instr(i_spgc_if.sleep_instr),
      .sleep_taken(i_spgc_if.sleep_taken),
      .bod_off_req(i_spgc_if.bod_off_req),
      .irq_block(i_spgc_if.irq_block), .sleep_mode(i_spgc_if.sleep_mode));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic sleep_ok(input logic [3:0] s);
      return s[0] && s[3:2] != 2'b10;
   endfunction
   task automatic sw_op(input logic w, input logic r, input logic [3:0] a,
                        input logic [7:0] d);
      sw_wr <= w;
      sw_rd <= r;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge core_clk_in);
   endtask
   task automatic idle(input int n);
      repeat (n) sw_op(1'b0, 1'b0, 4'h0, 8'h00);
   endtask
   // Data then go; block write strobes come two cycles apart
   task automatic put(input logic io, input logic [7:0] d);
      sw_op(1'b1, 1'b0, SPGC_CMD_WDATA, d);
      sw_op(1'b1, 1'b0, SPGC_CMD_GO, {io, 7'h01});
   endtask
   task automatic pair(input logic [7:0] a, input logic [7:0] d1,
                       input logic [7:0] d2);
      sw_op(1'b1, 1'b0, SPGC_CMD_ADDR, a);
      put(1'b0, d1);
      put(1'b0, d2);
      idle(2);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic io,
                         input logic [7:0] d);
      sw_op(1'b1, 1'b0, SPGC_CMD_ADDR, a);
      put(io, d);
      idle(2);
   endtask
   task automatic sw_get(input logic [3:0] a, output logic [7:0] d);
      sw_op(1'b0, 1'b1, a, 8'h00);
      #1 d = sw_rdata;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic io,
                         output logic [7:0] d);
      sw_op(1'b1, 1'b0, SPGC_CMD_ADDR, a);
      sw_op(1'b1, 1'b0, SPGC_CMD_GO, {io, 7'h02});
      idle(2);
      sw_get(SPGC_CMD_RDATA, d);
   endtask
   task automatic do_sleep(output logic [7:0] st);
      sw_op(1'b1, 1'b0, SPGC_CMD_GO, 8'h04);
      idle(3);
      sw_get(SPGC_CMD_STATUS, st);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk_in);
      errors++;
      give_verdict();
   end
   initial
   begin
      logic [7:0] r;
      logic [3:0] s;
      repeat (6) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge core_clk_in);
      `CHK("debug enable", 1'b1, dbg_en);
      wr_reg(8'h54, 1'b0, 8'hff);
      foreach (rofs[i])
      begin
         rd_reg(rofs[i], 1'b0, r);
         `CHK("reset or unmapped", 8'h00, r);
      end
      for (int j = 0; j < 6; j++)
      begin
         t2_async <= rnd[0];
         for (int k = 0; k < 3; k++)
         begin
            rnd = lfsr(rnd);
            gv[k] = (j == 0) ? 8'hff : rnd;
            wr_reg(gofs[k], 1'b0, gv[k]);
            rd_reg(gofs[k], 1'b0, r);
            `CHK("gate reg", gv[k] & gmsk[k], r);
         end
         `CHK("stop0", gv[0] & ~{1'b0, t2_async, 6'h0}, stop0);
         `CHK("stop1", gv[1][1:0], stop1);
         `CHK("stop2", gv[2][3:0], stop2);
      end
      for (int m = 0; m < 16; m++)
      begin
         s = m[3:0];
         wr_reg(m[1] ? 8'h33 : 8'h53, m[1], {4'h0, s});
         rd_reg(m[2] ? 8'h33 : 8'h53, m[2], r);
         `CHK("sleep reg", {4'h0, s}, r);
         do_sleep(r);
         `CHK("taken", sleep_ok(s), r[0]);
         if (sleep_ok(s))
            `CHK("mode", s[3:1], r[7:5]);
         wr_reg(8'h53, 1'b0, {4'h0, s[3:1], 1'b0});
         do_sleep(r);
         `CHK("no enable", 1'b0, r[0]);
      end
      wr_reg(8'h35, 1'b1, 8'h10);
      `CHK("pull off", 1'b1, pull_off);
      rd_reg(8'h55, 1'b0, r);
      `CHK("sysctl", 8'h10, r);
      wr_reg(8'h55, 1'b0, 8'h80);
      idle(4);
      `CHK("pull on", 1'b0, pull_off);
      `CHK("debug single", 1'b1, dbg_en);
      pair(8'h55, 8'h80, 8'h80);
      `CHK("debug double", 1'b0, dbg_en);
      dbg_fuse <= 1'b0;
      pair(8'h55, 8'h00, 8'h00);
      `CHK("debug fuse off", 1'b0, dbg_en);
      dbg_fuse <= 1'b1;
      idle(1);
      #1 `CHK("debug fuse on", 1'b1, dbg_en);
      wr_reg(8'h53, 1'b0, 8'h05);
      for (int j = 0; j < 3; j++)
      begin
         sw_op(1'b1, 1'b0, SPGC_CMD_ADDR, 8'h55);
         put(1'b0, 8'h60);
         if (j == 2)
            put(1'b0, 8'h00);
         put(1'b0, 8'h40);
         idle(j == 1 ? 0 : 3);
         do_sleep(r);
         `CHK("bod req", j == 0, r[1]);
         rd_reg(8'h55, 1'b0, r);
         `CHK("bod clear", 1'b0, r[6]);
      end
      boot_fuse <= {rnd, lfsr(rnd)};
      wr_reg(8'h55, 1'b0, 8'h02);
      `CHK("vec locked", 16'h0000, vec_base);
      for (int q = 1; q >= 0; q--)
      begin
         pair(8'h55, 8'h01, {6'h0, q[0], 1'b0});
         `CHK("vec base", q[0] ? boot_fuse : 16'h0000, vec_base);
         app_lock <= 1'b1;
         boot_lock <= 1'b1;
         for (int j = 0; j < 2; j++)
         begin
            in_boot <= j[0];
            idle(1);
            #1 `CHK("irq lock", j[0] != q[0], i_spgc_if.irq_block);
         end
         app_lock <= 1'b0;
         boot_lock <= 1'b0;
      end
      wr_reg(8'h55, 1'b0, 8'h01);
      idle(4);
      wr_reg(8'h55, 1'b0, 8'h02);
      `CHK("vec expired", 16'h0000, vec_base);
      `CHK("irq free", 1'b0, i_spgc_if.irq_block);
      give_verdict();
   end
endmodule
`default_nettype wire
